// ### inc/sps_params.svh
// Purpose: constants for the page stack block
// Assumes: byte-wide registers on a 32-bit classic bus
// Notes:   offsets are register indexes; byte address is four times
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
`define SPS_IDX_PAGE_SELECT   8'h84
`define SPS_IDX_STACK_SECOND  8'h85
`define SPS_IDX_STACK_THIRD   8'h86
`define SPS_IDX_AUTO_CONTROL  8'h96
`define SPS_PAGE_CONTROL      8'h0f
`define SPS_RST_PAGE_SELECT   8'h00
`define SPS_RST_STACK         8'h00
`define SPS_RST_AUTO_CONTROL  8'h01
`define SPS_BIT_AUTO_ENABLE   0
`define SPS_SFR_BASE          8'h80
`define SPS_ADR_LSB           2
`define SPS_ADR_MSB           9
`endif

// ### inc/sps_pkg.sv
// Purpose: types for the page stack block
// Assumes: nothing beyond the params header
// Notes:   none
package sps_pkg;
    typedef logic [7:0] sps_byte_t;
    typedef enum logic [1:0] {
        SPS_IDLE = 2'b00,
        SPS_ACK  = 2'b01
    } sps_bus_st_t;
endpackage : sps_pkg

// ### logic/sps_page_stack.sv
// Purpose: three-byte page stack with paged register decode
// Assumes: core gives one-cycle push and pop pulses on clk_i
// Notes:   classic wishbone slave, one wait state per access
//          writes land on the ack edge, read data is registered at the take
// Behaviour
// - The second stack byte is a read/write byte at 0x85 on every page, reset to zero.
// - The third stack byte is a read/write byte at 0x86 on every page, reset to zero.
// - The stack holds three bytes: active page, then second, then third.
// - Software access to a stack byte changes only that byte and never shifts the stack.
// - The stack shifts down only on interrupt service and up only on interrupt return.
// - A value written to the second byte becomes the active page on the next return.
// - Reading the second byte returns the page that the next return will activate.
// - A value written to the third byte moves into the second byte on the next return.
// - Reading the third byte returns the bottom entry of the stack.
// - Decode of 0x80 to 0xFF uses address and active page, stack bytes on all pages.
// - On entry with auto paging on, bytes shift down and the top takes the new page.
// - Bit 0 of the page control register, reset to one, enables the auto paging.
`timescale 1ns/1ps
`include "sps_params.svh"
module sps_page_stack
    import sps_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        irq_push_i,
    input  wire logic [7:0]  irq_page_i,
    input  wire logic        irq_pop_i,
    output logic      [7:0]  active_page_o,
    output logic             auto_paging_enable_o
);

    sps_byte_t   page_select_r;
    sps_byte_t   stack_second_r;
    sps_byte_t   stack_third_r;
    sps_byte_t   auto_control_r;
    sps_byte_t   page_select_nxt;
    sps_byte_t   stack_second_nxt;
    sps_byte_t   stack_third_nxt;
    sps_bus_st_t bus_st_r;
    logic [31:0] rdata_r;
    logic [7:0]  idx;
    logic        req;
    logic        wr_stb;
    logic        hit_sel;
    logic        hit_second;
    logic        hit_third;
    logic        hit_ctrl;
    logic        auto_en;
    logic        push;
    logic        pop;

    // register index decoded with the active page
    function automatic logic page_hit(input logic [7:0] a, input logic [7:0] want,
                                      input logic all_pages, input logic [7:0] pg);
        page_hit = (a == want) && (all_pages || (pg == `SPS_PAGE_CONTROL));
    endfunction : page_hit

    assign idx        = wb_adr_i[`SPS_ADR_MSB:`SPS_ADR_LSB];
    assign req        = wb_cyc_i && wb_stb_i && (bus_st_r == SPS_IDLE)
                        && (idx >= `SPS_SFR_BASE);
    assign wr_stb     = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
                        && (idx >= `SPS_SFR_BASE);                          // lands on ack edge
    assign hit_sel    = page_hit(idx, `SPS_IDX_PAGE_SELECT, 1'b1, page_select_r);
    assign hit_second = page_hit(idx, `SPS_IDX_STACK_SECOND, 1'b1, page_select_r);
    assign hit_third  = page_hit(idx, `SPS_IDX_STACK_THIRD, 1'b1, page_select_r);
    assign hit_ctrl   = page_hit(idx, `SPS_IDX_AUTO_CONTROL, 1'b0, page_select_r);
    assign auto_en    = auto_control_r[`SPS_BIT_AUTO_ENABLE];
    assign push       = irq_push_i && auto_en;
    assign pop        = irq_pop_i && auto_en && !irq_push_i;

    // write first, then shift
    always_comb begin
        page_select_nxt  = page_select_r;
        stack_second_nxt = stack_second_r;
        stack_third_nxt  = stack_third_r;
        if (wr_stb && hit_sel) begin
            page_select_nxt = wb_dat_i[7:0];
        end
        if (wr_stb && hit_second) begin
            stack_second_nxt = wb_dat_i[7:0];
        end
        if (wr_stb && hit_third) begin
            stack_third_nxt = wb_dat_i[7:0];
        end
        if (push) begin
            stack_third_nxt  = stack_second_nxt;
            stack_second_nxt = page_select_nxt;
            page_select_nxt  = irq_page_i;
        end else if (pop) begin
            page_select_nxt  = stack_second_nxt;
            stack_second_nxt = stack_third_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page_select_r <= `SPS_RST_PAGE_SELECT;
        end else begin
            page_select_r <= page_select_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stack_second_r <= `SPS_RST_STACK;
        end else begin
            stack_second_r <= stack_second_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stack_third_r <= `SPS_RST_STACK;
        end else begin
            stack_third_r <= stack_third_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_control_r <= `SPS_RST_AUTO_CONTROL;
        end else if (wr_stb && hit_ctrl) begin
            auto_control_r <= {7'h00, wb_dat_i[`SPS_BIT_AUTO_ENABLE]};
        end
    end

    // bus answer: one ack per request, unmapped reads as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_st_r <= SPS_IDLE;
            rdata_r  <= 32'h0000_0000;
        end else begin
            unique case (bus_st_r)
                SPS_IDLE: begin
                    if (wb_cyc_i && wb_stb_i) begin
                        bus_st_r <= SPS_ACK;
                        rdata_r  <= 32'h0000_0000;
                        if (req && hit_sel) begin
                            rdata_r <= {24'h000000, page_select_r};
                        end else if (req && hit_second) begin
                            rdata_r <= {24'h000000, stack_second_r};
                        end else if (req && hit_third) begin
                            rdata_r <= {24'h000000, stack_third_r};
                        end else if (req && hit_ctrl) begin
                            rdata_r <= {24'h000000, auto_control_r};
                        end
                    end
                end
                SPS_ACK: begin
                    bus_st_r <= SPS_IDLE;
                end
                default: begin
                    bus_st_r <= SPS_IDLE;
                end
            endcase
        end
    end

    assign wb_ack_o             = (bus_st_r == SPS_ACK);
    assign wb_dat_o             = rdata_r;
    assign active_page_o        = page_select_r;
    assign auto_paging_enable_o = auto_en;

    property p_push;
        @(posedge clk_i) disable iff (rst_i)
        (push && !wr_stb) |=> (page_select_r == $past(irq_page_i))
            && (stack_second_r == $past(page_select_r))
            && (stack_third_r == $past(stack_second_r));
    endproperty
    stack_push_a: assert property (p_push) else $error("push shift wrong");

    stack_pop_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (pop && !wr_stb) |=> (page_select_r == $past(stack_second_r))
            && (stack_second_r == $past(stack_third_r))
    ) else $error("pop shift wrong");

    stack_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!irq_push_i && !irq_pop_i && !wr_stb) |=> $stable(page_select_r)
            && $stable(stack_second_r) && $stable(stack_third_r)
    ) else $error("stack moved without event");

    second_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_stb && hit_second && !push && !pop) |=> (stack_second_r == $past(wb_dat_i[7:0]))
            && $stable(page_select_r) && $stable(stack_third_r)
    ) else $error("second byte write wrong");

    third_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_stb && hit_third && !push && !pop) |=> (stack_third_r == $past(wb_dat_i[7:0]))
            && $stable(stack_second_r) && $stable(page_select_r)
    ) else $error("third byte write wrong");

    second_read_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_second) |=> wb_ack_o && (wb_dat_o[7:0] == $past(stack_second_r))
    ) else $error("second byte read wrong");

    third_read_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_third) |=> wb_ack_o && (wb_dat_o[7:0] == $past(stack_third_r))
    ) else $error("third byte read wrong");

    auto_off_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!auto_en && !wr_stb) |=> $stable(page_select_r) && $stable(stack_second_r)
    ) else $error("stack moved while disabled");

    write_then_push_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (push && wr_stb && hit_sel) |=> (stack_second_r == $past(wb_dat_i[7:0]))
    ) else $error("write not applied before push");

    ctrl_page_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_stb && (idx == `SPS_IDX_AUTO_CONTROL) && (page_select_r != `SPS_PAGE_CONTROL))
            |=> $stable(auto_control_r)
    ) else $error("control written off its page");

    // bus answer checks
    ack_pulse_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o
    ) else $error("ack held for two cycles");

    ack_answer_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o
    ) else $error("request not answered");

    ack_cause_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!(wb_cyc_i && wb_stb_i) && !wb_ack_o) |=> !wb_ack_o
    ) else $error("ack without request");

    read_upper_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000)
    ) else $error("upper read bits not zero");

    // decode and read checks
    low_index_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o && (idx < `SPS_SFR_BASE))
            |=> (wb_dat_o == 32'h0000_0000)
    ) else $error("low index read not zero");

    ctrl_hidden_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && (idx == `SPS_IDX_AUTO_CONTROL)
            && (page_select_r != `SPS_PAGE_CONTROL)) |=> (wb_dat_o == 32'h0000_0000)
    ) else $error("control seen off its page");

    unmapped_read_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && !hit_sel && !hit_second && !hit_third && !hit_ctrl)
            |=> (wb_dat_o == 32'h0000_0000)
    ) else $error("unmapped read not zero");

    sel_read_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_sel) |=> wb_ack_o && (wb_dat_o[7:0] == $past(page_select_r))
    ) else $error("top byte read wrong");

    ctrl_read_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_ctrl) |=> wb_ack_o && (wb_dat_o[7:0] == $past(auto_control_r))
    ) else $error("control read wrong");

    // write and stack checks
    sel_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_stb && hit_sel && !push && !pop) |=> (page_select_r == $past(wb_dat_i[7:0]))
            && $stable(stack_second_r) && $stable(stack_third_r)
    ) else $error("top byte write wrong");

    ctrl_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_stb && hit_ctrl) |=> (auto_en == $past(wb_dat_i[`SPS_BIT_AUTO_ENABLE]))
    ) else $error("control write wrong");

    write_early_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !irq_push_i && !irq_pop_i)
            |=> $stable(page_select_r) && $stable(stack_second_r) && $stable(stack_third_r)
    ) else $error("write landed before ack");

    read_still_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && !irq_push_i && !irq_pop_i)
            |=> $stable(page_select_r) && $stable(stack_second_r) && $stable(stack_third_r)
    ) else $error("read moved the stack");

    push_wins_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (irq_push_i && irq_pop_i && auto_en && !wr_stb)
            |=> (page_select_r == $past(irq_page_i)) && (stack_second_r == $past(page_select_r))
    ) else $error("push did not win over pop");

    paging_off_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ((irq_push_i || irq_pop_i) && !auto_en && !wr_stb)
            |=> $stable(page_select_r) && $stable(stack_second_r) && $stable(stack_third_r)
    ) else $error("stack moved with paging off");

    pop_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (pop && wr_stb && hit_second) |=> (page_select_r == $past(wb_dat_i[7:0]))
    ) else $error("second write not applied before pop");

    pop_third_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (pop && wr_stb && hit_third) |=> (stack_second_r == $past(wb_dat_i[7:0]))
    ) else $error("third write not applied before pop");

    push_third_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (push && wr_stb && hit_third) |=> (stack_third_r == $past(stack_second_r))
    ) else $error("bottom not overwritten by push");

    pop_top_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (pop && wr_stb && hit_sel) |=> (page_select_r == $past(stack_second_r))
    ) else $error("pop did not replace top");

endmodule : sps_page_stack

// ### verification/sps_core_model.sv
// Purpose: core side that pulses interrupt entry and return
// Assumes: tasks are called right after a rising clock edge
// Notes:   after each entry the page lines hold the inverted page until the next entry
`timescale 1ns/1ps
module sps_core_model (
    input  wire logic       clk_i,
    output logic            irq_push_o,
    output logic [7:0]      irq_page_o,
    output logic            irq_pop_o
);
    initial begin
        irq_push_o = 1'b0;
        irq_pop_o  = 1'b0;
        irq_page_o = 8'h00;
    end
    // one-cycle entry pulse carrying the page of the source
    task automatic enter(input logic [7:0] pg);
        irq_push_o <= 1'b1;
        irq_page_o <= pg;
        @(posedge clk_i);
        irq_push_o <= 1'b0;
        irq_page_o <= ~pg;
    endtask : enter
    task automatic leave();
        irq_pop_o <= 1'b1;
        @(posedge clk_i);
        irq_pop_o <= 1'b0;
    endtask : leave
endmodule : sps_core_model

// ### verification/tb_top.sv
// Purpose: self-checking bench for the page stack
// Assumes: single clock, classic bus single cycles
// Notes:   table rows first, stack moves after
`timescale 1ns/1ps
`include "sps_params.svh"
module tb_top
    import sps_pkg::*;
;
    typedef struct {logic we; logic [7:0] idx; sps_byte_t wd; sps_byte_t ex;} sps_row_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat;
    logic [3:0]  sel = 4'h0;
    logic        ack, push, pop, auto_en;
    logic [7:0]  page, act;
    sps_byte_t   rd;
    int          fail_count = 0;
    int          cmp_count = 0;
    sps_row_t    rows [7] = '{
        '{1'b1, `SPS_IDX_PAGE_SELECT,  8'h0f, 8'h0f},
        '{1'b0, `SPS_IDX_AUTO_CONTROL, 8'h00, 8'h01},
        '{1'b1, `SPS_IDX_STACK_SECOND, 8'h3c, 8'h3c},
        '{1'b1, `SPS_IDX_STACK_THIRD,  8'h5a, 8'h5a},
        '{1'b0, `SPS_IDX_STACK_SECOND, 8'h00, 8'h3c},
        '{1'b0, 8'h80,                 8'h00, 8'h00},
        '{1'b0, 8'h10,                 8'h00, 8'h00}};
    always #2.5 clk_i = ~clk_i;
    sps_page_stack uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_push_i(push), .irq_page_i(page), .irq_pop_i(pop),
        .active_page_o(act), .auto_paging_enable_o(auto_en));
    sps_core_model core (.clk_i(clk_i), .irq_push_o(push), .irq_page_o(page),
        .irq_pop_o(pop));
    task automatic check(input sps_byte_t got, input sps_byte_t ex, input string what);
        cmp_count++;
        if (got !== ex) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, ex);
        end
    endtask : check
    // one classic cycle, held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] idx, input sps_byte_t d);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= 4'h1;
        adr  <= {22'h0, idx, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (3000) @(posedge clk_i);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        xfer(1'b0, `SPS_IDX_STACK_THIRD, 8'h00);
        check(rd, `SPS_RST_STACK, "third after reset");
        check(act, 8'h00, "top after reset");
        $display("test reset done");
        foreach (rows[i]) begin
            if (rows[i].we) xfer(1'b1, rows[i].idx, rows[i].wd);
            xfer(1'b0, rows[i].idx, 8'h00);
            check(rd, rows[i].ex, "row readback");
        end
        check(act, 8'h0f, "top not shifted by access");
        $display("test table done");
        core.leave();
        @(posedge clk_i);
        check(act, 8'h3c, "second moved to top");
        xfer(1'b0, `SPS_IDX_STACK_SECOND, 8'h00);
        check(rd, 8'h5a, "third moved to second");
        core.enter(8'h02);
        @(posedge clk_i);
        check(act, 8'h02, "entry page on top");
        xfer(1'b0, `SPS_IDX_STACK_SECOND, 8'h00);
        check(rd, 8'h3c, "top pushed to second");
        xfer(1'b0, `SPS_IDX_STACK_THIRD, 8'h00);
        check(rd, 8'h5a, "second pushed to third");
        $display("test stack moves done");
        xfer(1'b1, `SPS_IDX_PAGE_SELECT, 8'h0f);
        xfer(1'b1, `SPS_IDX_AUTO_CONTROL, 8'h00);
        check({7'h0, auto_en}, 8'h00, "auto paging off");
        core.enter(8'h03);
        core.leave();
        @(posedge clk_i);
        check(act, 8'h0f, "no shift while off");
        $display("test auto off done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(act, `SPS_RST_PAGE_SELECT, "top after second reset");
        check({7'h0, auto_en}, `SPS_RST_AUTO_CONTROL, "auto paging back on");
        xfer(1'b0, `SPS_IDX_STACK_SECOND, 8'h00);
        check(rd, `SPS_RST_STACK, "second after second reset");
        xfer(1'b1, `SPS_IDX_AUTO_CONTROL, 8'h00);
        xfer(1'b0, `SPS_IDX_AUTO_CONTROL, 8'h00);
        check(rd, 8'h00, "control hidden off its page");
        check({7'h0, auto_en}, `SPS_RST_AUTO_CONTROL, "control write refused");
        $display("test second reset done");
        fork
            xfer(1'b1, `SPS_IDX_PAGE_SELECT, 8'h03);
            begin
                @(posedge clk_i);
                core.enter(8'h01);
            end
        join
        check(act, 8'h01, "entry page over written top");
        xfer(1'b0, `SPS_IDX_STACK_SECOND, 8'h00);
        check(rd, 8'h03, "written top pushed to second");
        $display("test write with entry done");
        complete_run();
    end
endmodule : tb_top
